// ### rtl/regbank_pkg.sv
// Constants shared by the control register bank and its queue memory.
// Assumes a 32-bit APB slave; each register takes one aligned word at index*4.
`default_nettype none

package regbank_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_OPERATION_CONTROL  = 6'h00;
	localparam logic [5:0] IDX_BUS_ACCESS_CONTROL = 6'h01;
	localparam logic [5:0] IDX_QUEUE_CONTROL      = 6'h02;
	localparam logic [5:0] IDX_WARNING_THRESHOLD  = 6'h03;
	localparam logic [5:0] IDX_FILL_COUNT         = 6'h04;
	localparam logic [5:0] IDX_QUEUE_DATA_PORT    = 6'h05;
	localparam logic [5:0] IDX_EVENT_STATUS       = 6'h08;
	localparam logic [5:0] IDX_EVENT_MASK         = 6'h09;
	localparam int         ADDR_W                 = 8;

	// operation_control fields
	localparam int BIT_STANDBY         = 7;
	localparam int BIT_RF_POWERDOWN    = 6;
	localparam int CMD_W               = 5;

	// bus_access_control fields
	localparam int BIT_ACCESS_UNLOCK   = 7;
	localparam int BIT_MAIN_OWNS       = 6;
	localparam int BIT_SECURE_OWNS     = 5;
	localparam int LINK_SEL_LSB        = 2;
	localparam logic [1:0] LINK_OFF    = 2'h0;
	localparam logic [1:0] LINK_SPI    = 2'h1;
	localparam logic [1:0] LINK_I2C_LS = 2'h2;
	localparam logic [1:0] LINK_I2C    = 2'h3;

	// queue_control fields
	localparam int BIT_DEPTH_SELECT    = 7;
	localparam int BIT_NEAR_FULL       = 6;
	localparam int BIT_NEAR_EMPTY      = 5;
	localparam int BIT_QUEUE_CLEAR     = 4;
	localparam int BIT_THRESHOLD_MSB   = 2;

	// queue geometry
	localparam int          FILL_W     = 10;
	localparam int          PTR_W      = 9;
	localparam int          QDATA_W    = 8;
	localparam int          QDEPTH     = 512;
	localparam logic [9:0]  CAP_SMALL  = 10'h0ff;
	localparam logic [9:0]  CAP_LARGE  = 10'h200;

	// event status / mask bits
	localparam int EVT_W               = 4;
	localparam int EVT_NEAR_FULL       = 0;
	localparam int EVT_NEAR_EMPTY      = 1;
	localparam int EVT_OVERFLOW        = 2;
	localparam int EVT_UNDERFLOW       = 3;

	// reset values
	localparam logic [7:0] RST_OPERATION_CONTROL  = 8'h00;
	localparam logic [7:0] RST_BUS_ACCESS_CONTROL = 8'h00;
	localparam logic [7:0] RST_WARNING_THRESHOLD  = 8'h00;
	localparam logic [3:0] RST_EVENT_MASK         = 4'h0;

endpackage

`default_nettype wire

// ### rtl/queue_mem.sv
// Byte memory behind the queue data port, one write and one registered read.
// Assumes the caller keeps addresses below the depth; contents are not reset.
`timescale 1ns/1ps
`default_nettype none

module queue_mem
	import regbank_pkg::*;
(
	input  wire logic               pclk,
	input  wire logic               wr_en,
	input  wire logic [PTR_W-1:0]   wr_addr,
	input  wire logic [QDATA_W-1:0] wr_data,
	input  wire logic [PTR_W-1:0]   rd_addr,
	output logic      [QDATA_W-1:0] rd_data
);

	logic [QDATA_W-1:0] mem [QDEPTH];

	// storage write
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read of the head entry
	always_ff @(posedge pclk) begin
		rd_data <= mem[rd_addr];
	end

endmodule // queue_mem

`default_nettype wire

// ### rtl/cmd_host_fifo_config_regs.sv
// Control register bank: operation control, bus ownership, queue control and threshold.
// Assumes an APB master on pclk; zero wait states; pslverr on unmapped addresses.
//
// Behaviour
// R1: writing one to operation control bit 7 enters whole-device power-down.
// R2: operation control bit 6 powers down receiver and transmitter; read/write.
// R3: bits 4..0 choose the command; a write starts or stops it; bit 5 reserved.
// R4: unlock bit permits the next change; the next write clears it.
// R5: main-controller ownership bit may be set only after unlock.
// R6: secure-module ownership bit may be set only after unlock.
// R7: both ownership bits are never set together.
// R8: bits 3..2 select secure module link: off, SPI, slow I2C, I2C.
// R9: depth select bit 7: one gives 255 bytes, zero gives 512.
// R10: host should change depth only after clearing the queue.
// R11: near-full reads one when capacity minus fill is at most threshold.
// R12: near-empty reads one when fill is at most threshold.
// R13: writing one to clear bit empties the queue; bit reads zero.
// R14: threshold bit 8 lives in queue control, used only in 512 mode.
// R15: queue control bits 1..0 show fill count bits 9 and 8.
// R16: threshold register holds threshold bits 7..0 for both flags.
// R17: fill count rises per data port write unless full and falls per read unless empty.
// R18: unlocked-less or double-owner writes leave ownership bits unchanged.
// R19: in 255 mode threshold bit 8 ignored, fill upper bits read zero.
`timescale 1ns/1ps
`default_nettype none

module cmd_host_fifo_config_regs
	import regbank_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   irq,
	output logic                   device_powerdown,
	output logic                   rf_frontend_powerdown,
	output logic      [CMD_W-1:0]  command_code,
	output logic                   command_start,
	output logic                   main_controller_owns_bus,
	output logic                   secure_module_owns_bus,
	output logic      [1:0]        secure_module_link_select
);

	// bus decode
	logic             access;
	logic             wr_en;
	logic             rd_en;
	logic [5:0]       idx;
	logic             mapped;
	logic             low_lane;
	assign access   = psel && penable;
	assign wr_en    = access && pwrite && mapped && low_lane;
	assign rd_en    = access && !pwrite && mapped;
	assign idx      = paddr[7:2];
	assign low_lane = pstrb[0];
	assign mapped   = (paddr[1:0] == 2'h0) &&
	                  (idx <= IDX_QUEUE_DATA_PORT || idx == IDX_EVENT_STATUS || idx == IDX_EVENT_MASK);
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !mapped;

	logic wr_op, wr_bus, wr_qc, wr_thr, wr_data, rd_data, wr_stat, wr_mask;
	assign wr_op   = wr_en && idx == IDX_OPERATION_CONTROL;
	assign wr_bus  = wr_en && idx == IDX_BUS_ACCESS_CONTROL;
	assign wr_qc   = wr_en && idx == IDX_QUEUE_CONTROL;
	assign wr_thr  = wr_en && idx == IDX_WARNING_THRESHOLD;
	assign wr_data = wr_en && idx == IDX_QUEUE_DATA_PORT;
	assign rd_data = rd_en && idx == IDX_QUEUE_DATA_PORT;
	assign wr_stat = wr_en && idx == IDX_EVENT_STATUS;
	assign wr_mask = wr_en && idx == IDX_EVENT_MASK;

	// operation control: standby, rf power-down, command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			device_powerdown      <= RST_OPERATION_CONTROL[BIT_STANDBY];
			rf_frontend_powerdown <= RST_OPERATION_CONTROL[BIT_RF_POWERDOWN];
			command_code          <= RST_OPERATION_CONTROL[CMD_W-1:0];
			command_start         <= 1'b0;
		end else begin
			command_start <= wr_op;
			if (wr_op) begin
				// R1: standby power-down
				device_powerdown      <= pwdata[BIT_STANDBY];
				// R2: rf front end off
				rf_frontend_powerdown <= pwdata[BIT_RF_POWERDOWN];
				// R3: command select
				command_code          <= pwdata[CMD_W-1:0];
			end
		end
	end

	// bus access control: unlock, owners, link select
	logic access_unlock_reg;
	logic both_owners;
	assign both_owners = pwdata[BIT_MAIN_OWNS] && pwdata[BIT_SECURE_OWNS];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			access_unlock_reg         <= RST_BUS_ACCESS_CONTROL[BIT_ACCESS_UNLOCK];
			main_controller_owns_bus  <= RST_BUS_ACCESS_CONTROL[BIT_MAIN_OWNS];
			secure_module_owns_bus    <= RST_BUS_ACCESS_CONTROL[BIT_SECURE_OWNS];
			secure_module_link_select <= RST_BUS_ACCESS_CONTROL[LINK_SEL_LSB+1:LINK_SEL_LSB];
		end else if (wr_bus) begin
			// R8: link select
			secure_module_link_select <= pwdata[LINK_SEL_LSB+1:LINK_SEL_LSB];
			if (access_unlock_reg) begin
				// R4: next write clears unlock
				access_unlock_reg <= 1'b0;
				// R5: owner changes need unlock
				// R6: owner changes need unlock
				// R7: never both owners
				if (!both_owners) begin
					main_controller_owns_bus <= pwdata[BIT_MAIN_OWNS];
					secure_module_owns_bus   <= pwdata[BIT_SECURE_OWNS];
				end
			end else begin
				// R18: locked write keeps owners
				access_unlock_reg <= pwdata[BIT_ACCESS_UNLOCK];
			end
		end
	end

	// queue control and threshold storage
	logic       depth_select_reg;
	logic       threshold_msb_reg;
	logic [7:0] threshold_low_bits_reg;
	logic       queue_clear;
	assign queue_clear = wr_qc && pwdata[BIT_QUEUE_CLEAR];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			depth_select_reg       <= 1'b0;
			threshold_msb_reg      <= 1'b0;
			threshold_low_bits_reg <= RST_WARNING_THRESHOLD;
		end else begin
			if (wr_qc) begin
				// R9: capacity select
				depth_select_reg  <= pwdata[BIT_DEPTH_SELECT];
				// R14: threshold bit 8 store
				threshold_msb_reg <= pwdata[BIT_THRESHOLD_MSB];
			end
			// R16: threshold low byte
			if (wr_thr) begin
				threshold_low_bits_reg <= pwdata[7:0];
			end
		end
	end

	// capacity and effective threshold
	logic [FILL_W-1:0] capacity;
	logic [FILL_W-1:0] threshold;
	assign capacity = depth_select_reg ? CAP_SMALL : CAP_LARGE;
	// R14: msb only in 512 mode
	// R19: msb ignored in 255 mode
	assign threshold = {1'b0, threshold_msb_reg && !depth_select_reg, threshold_low_bits_reg};

	// queue pointers and fill count
	logic [FILL_W-1:0]  fill_count_reg;
	logic [PTR_W-1:0]   wr_ptr_reg;
	logic [PTR_W-1:0]   rd_ptr_reg;
	logic               push;
	logic               pop;
	logic               queue_full;
	logic               queue_empty;
	logic [QDATA_W-1:0] head_data;
	assign queue_full  = fill_count_reg >= capacity;
	assign queue_empty = fill_count_reg == '0;
	assign push        = wr_data && !queue_full;
	assign pop         = rd_data && !queue_empty;

	function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic [FILL_W-1:0] cap);
		logic [FILL_W-1:0] nxt;
		nxt = {1'b0, p} + 10'h001;
		ptr_step = (nxt >= cap) ? '0 : nxt[PTR_W-1:0];
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fill_count_reg <= '0;
			wr_ptr_reg     <= '0;
			rd_ptr_reg     <= '0;
		end else if (queue_clear) begin
			// R13: clear empties queue
			fill_count_reg <= '0;
			wr_ptr_reg     <= '0;
			rd_ptr_reg     <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ptr_step(wr_ptr_reg, capacity);
			end
			if (pop) begin
				rd_ptr_reg <= ptr_step(rd_ptr_reg, capacity);
			end
			// R17: fill count up/down
			case ({push, pop})
				2'b10:   fill_count_reg <= fill_count_reg + 10'h001;
				2'b01:   fill_count_reg <= fill_count_reg - 10'h001;
				default: fill_count_reg <= fill_count_reg;
			endcase
		end
	end

	queue_mem u_queue_mem (
		.pclk    (pclk),
		.wr_en   (push),
		.wr_addr (wr_ptr_reg),
		.wr_data (pwdata[QDATA_W-1:0]),
		.rd_addr (rd_ptr_reg),
		.rd_data (head_data)
	);

	// alert flags from threshold
	logic [FILL_W:0] room;
	logic            near_full_flag;
	logic            near_empty_flag;
	assign room = {1'b0, capacity} - {1'b0, fill_count_reg};
	// R11: near-full compare
	assign near_full_flag  = room[FILL_W] || (room[FILL_W-1:0] <= threshold);
	// R12: near-empty compare
	assign near_empty_flag = fill_count_reg <= threshold;

	// sticky events, write one to clear, set wins
	logic             near_full_d_reg;
	logic             near_empty_d_reg;
	logic [EVT_W-1:0] event_status_reg;
	logic [EVT_W-1:0] event_mask_reg;
	logic [EVT_W-1:0] event_set;
	always_comb begin
		event_set                 = '0;
		event_set[EVT_NEAR_FULL]  = near_full_flag && !near_full_d_reg;
		event_set[EVT_NEAR_EMPTY] = near_empty_flag && !near_empty_d_reg;
		event_set[EVT_OVERFLOW]   = wr_data && queue_full;
		event_set[EVT_UNDERFLOW]  = rd_data && queue_empty;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			near_full_d_reg  <= 1'b0;
			near_empty_d_reg <= 1'b1;
			event_status_reg <= '0;
			event_mask_reg   <= RST_EVENT_MASK;
		end else begin
			near_full_d_reg  <= near_full_flag;
			near_empty_d_reg <= near_empty_flag;
			event_status_reg <= (event_status_reg & ~(wr_stat ? pwdata[EVT_W-1:0] : '0)) | event_set;
			if (wr_mask) begin
				event_mask_reg <= pwdata[EVT_W-1:0];
			end
		end
	end

	assign irq = |(event_status_reg & event_mask_reg);

	// read data mux
	logic [7:0] qc_read;
	// R15: fill upper bits
	// R19: zero in 255 mode
	assign qc_read = {depth_select_reg, near_full_flag, near_empty_flag, 1'b0, 1'b0, threshold_msb_reg,
	                  depth_select_reg ? 2'h0 : fill_count_reg[9:8]};
	always_comb begin
		prdata = '0;
		if (rd_en) begin
			case (idx)
				IDX_OPERATION_CONTROL:  prdata[7:0] = {device_powerdown, rf_frontend_powerdown, 1'b0, command_code};
				IDX_BUS_ACCESS_CONTROL: prdata[7:0] = {access_unlock_reg, main_controller_owns_bus,
				                                       secure_module_owns_bus, 1'b0, secure_module_link_select, 2'h0};
				IDX_QUEUE_CONTROL:      prdata[7:0] = qc_read;
				IDX_WARNING_THRESHOLD:  prdata[7:0] = threshold_low_bits_reg;
				IDX_FILL_COUNT:         prdata[7:0] = fill_count_reg[7:0];
				IDX_QUEUE_DATA_PORT:    prdata[7:0] = head_data;
				IDX_EVENT_STATUS:       prdata[EVT_W-1:0] = event_status_reg;
				IDX_EVENT_MASK:         prdata[EVT_W-1:0] = event_mask_reg;
				default:                prdata = '0;
			endcase
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_standby;
		wr_op |=> device_powerdown == $past(pwdata[BIT_STANDBY]);
	endproperty
	a_standby: assert property (p_standby) else $error("standby bit not taken"); // R1

	property p_rf_off;
		1'b1 |=> rf_frontend_powerdown == ($past(wr_op) ? $past(pwdata[BIT_RF_POWERDOWN])
		                                                : $past(rf_frontend_powerdown));
	endproperty
	a_rf_off: assert property (p_rf_off) else $error("rf power-down not as written"); // R2

	property p_command;
		wr_op |=> command_start && command_code == $past(pwdata[CMD_W-1:0]);
	endproperty
	a_command: assert property (p_command) else $error("command not started"); // R3

	property p_unlock_clear;
		wr_bus && access_unlock_reg |=> !access_unlock_reg;
	endproperty
	a_unlock_clear: assert property (p_unlock_clear) else $error("unlock not cleared"); // R4

	property p_locked_owner;
		wr_bus && !access_unlock_reg |=> $stable(main_controller_owns_bus) && $stable(secure_module_owns_bus);
	endproperty
	a_locked_owner: assert property (p_locked_owner) else $error("owner changed while locked"); // R18

	property p_unlocked_owner;
		wr_bus && access_unlock_reg && !both_owners |=> main_controller_owns_bus == $past(pwdata[BIT_MAIN_OWNS]);
	endproperty
	a_unlocked_owner: assert property (p_unlocked_owner) else $error("owner not set after unlock"); // R5

	property p_exclusive;
		!(main_controller_owns_bus && secure_module_owns_bus);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("both owners set"); // R7

	property p_link;
		wr_bus |=> secure_module_link_select == $past(pwdata[3:2]);
	endproperty
	a_link: assert property (p_link) else $error("link select not taken"); // R8

	property p_near_empty;
		near_empty_flag == ({1'b0, fill_count_reg} <= {2'b00, !depth_select_reg && threshold_msb_reg,
		                                               threshold_low_bits_reg});
	endproperty
	a_near_empty: assert property (p_near_empty) else $error("near-empty flag wrong"); // R12

	property p_near_full;
		(fill_count_reg <= capacity) |-> near_full_flag == ((capacity - fill_count_reg) <= threshold);
	endproperty
	a_near_full: assert property (p_near_full) else $error("near-full flag wrong"); // R11

	property p_clear;
		queue_clear |=> fill_count_reg == '0 && wr_ptr_reg == '0 && rd_ptr_reg == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not empty queue"); // R13

	property p_push;
		push && !pop && !queue_clear |=> fill_count_reg == $past(fill_count_reg) + 10'h001;
	endproperty
	a_push: assert property (p_push) else $error("fill count did not rise"); // R17

	property p_small_ext;
		depth_select_reg |-> qc_read[1:0] == 2'h0 && fill_count_reg <= CAP_SMALL;
	endproperty
	a_small_ext: assert property (p_small_ext) else $error("upper fill bits in small mode"); // R19

	property p_cap;
		fill_count_reg <= CAP_LARGE;
	endproperty
	a_cap: assert property (p_cap) else $error("fill above capacity"); // R9

	c_clear:   cover property (queue_clear && fill_count_reg != '0);
	c_unlock:  cover property (wr_bus && access_unlock_reg && !both_owners);
	c_irq:     cover property ($rose(irq));
	c_full:    cover property (queue_full && !depth_select_reg);

endmodule // cmd_host_fifo_config_regs

`default_nettype wire

// ### sim/apb_host_model.sv
// APB host model: runs single transfers for the bench, one at a time.
// Assumes a slave on pclk; the answer is taken at the edge that sees pready.
`timescale 1ns/1ps
`default_nettype none

module apb_host_model (
	input  wire logic        pclk,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [7:0]  paddr,
	output var  logic [31:0] pwdata,
	output var  logic [3:0]  pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic [31:0] rdata_h;
	logic        ready_h;
	logic        err_h;

	// answer as it stands just before each rising edge, free of update races
	always @(negedge pclk) begin
		rdata_h = prdata;
		ready_h = pready;
		err_h   = pslverr;
	end

	// idle bus from time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		pstrb   = 4'h0;
	end

	// setup cycle, then access held until pready is seen high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (ready_h !== 1'b1);
		q = rdata_h;
		e = err_h;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // apb_host_model

`default_nettype wire

// ### sim/cmd_host_fifo_config_regs_bench.sv
// Self-checking bench for the control register bank, one task per scenario.
// Assumes the APB host model drives the bus; clock 200 MHz.
`timescale 1ns/1ps
`default_nettype none

module cmd_host_fifo_config_regs_bench;
	import regbank_pkg::*;
	localparam logic [7:0] A_OP = {IDX_OPERATION_CONTROL, 2'b00};
	localparam logic [7:0] A_BUS = {IDX_BUS_ACCESS_CONTROL, 2'b00};
	localparam logic [7:0] A_QC = {IDX_QUEUE_CONTROL, 2'b00};
	localparam logic [7:0] A_THR = {IDX_WARNING_THRESHOLD, 2'b00};
	localparam logic [7:0] A_FILL = {IDX_FILL_COUNT, 2'b00};
	localparam logic [7:0] A_DATA = {IDX_QUEUE_DATA_PORT, 2'b00};
	localparam logic [7:0] A_EVS = {IDX_EVENT_STATUS, 2'b00};
	localparam logic [7:0] A_EVM = {IDX_EVENT_MASK, 2'b00};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, command_start;
	logic device_powerdown, rf_frontend_powerdown, main_controller_owns_bus, secure_module_owns_bus;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [CMD_W-1:0] command_code;
	logic [1:0] secure_module_link_select;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;

	cmd_host_fifo_config_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .device_powerdown(device_powerdown),
		.rf_frontend_powerdown(rf_frontend_powerdown), .command_code(command_code),
		.command_start(command_start), .main_controller_owns_bus(main_controller_owns_bus),
		.secure_module_owns_bus(secure_module_owns_bus), .secure_module_link_select(secure_module_link_select));
	apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		host.xfer(1'b1, a, {24'h0, d}, 4'hf, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [31:0] q;
		logic        e;
		host.xfer(1'b0, a, 32'h0, 4'hf, q, e);
		chk(q, {24'h0, exp}, what);
	endtask

	task automatic end_of_test();
		$display("Checks %0d, errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// reset state at the ports and in the registers
	task automatic t_reset();
		chk({irq, device_powerdown, rf_frontend_powerdown, command_code}, 32'h0, "outputs after reset");
		chk({main_controller_owns_bus, secure_module_owns_bus, secure_module_link_select}, 32'h0, "owners");
		rd(A_OP, 8'h00, "op reset");
		rd(A_BUS, 8'h00, "bus reset");
		rd(A_QC, 8'h20, "qc reset");
		rd(A_THR, 8'h00, "thr reset");
	endtask

	// command, power-down and start pulse
	task automatic t_opctl();
		wr(A_OP, 8'hc5);
		#1 chk(command_start, 1'b1, "start pulse");
		@(posedge pclk);
		#1 chk(command_start, 1'b0, "pulse ends");
		chk({device_powerdown, rf_frontend_powerdown, command_code}, {2'b11, 5'h05}, "op outputs");
		rd(A_OP, 8'hc5, "op readback");
		wr(A_OP, 8'h00);
		#1 chk({device_powerdown, rf_frontend_powerdown, command_code}, 32'h0, "op cleared");
	endtask

	// ownership arbitration and link select
	task automatic t_bus();
		wr(A_BUS, 8'h40);
		rd(A_BUS, 8'h00, "owner without unlock");
		wr(A_BUS, 8'h80);
		rd(A_BUS, 8'h80, "unlock held over read");
		wr(A_BUS, 8'h44);
		rd(A_BUS, 8'h44, "main owner set");
		chk(main_controller_owns_bus, 1'b1, "main port");
		wr(A_BUS, 8'h80);
		wr(A_BUS, 8'h60);
		rd(A_BUS, 8'h40, "both owners refused");
		wr(A_BUS, 8'h80);
		wr(A_BUS, 8'h2c);
		rd(A_BUS, 8'h2c, "secure owner set");
		for (int i = 0; i < 4; i++) begin
			wr(A_BUS, {4'h0, 2'(i), 2'b00});
			#1 chk({main_controller_owns_bus, secure_module_owns_bus, secure_module_link_select},
				{2'b01, 2'(i)}, "link select");
		end
	endtask

	// queue depth, thresholds, flags and fill count
	task automatic t_queue();
		logic [31:0] q;
		logic        e;
		wr(A_THR, 8'h02);
		host.xfer(1'b1, A_THR, 32'h55, 4'he, q, e);
		rd(A_THR, 8'h02, "threshold, strobe off");
		wr(A_DATA, 8'h11);
		wr(A_DATA, 8'h22);
		wr(A_DATA, 8'h33);
		rd(A_FILL, 8'h03, "fill after pushes");
		rd(A_QC, 8'h00, "no flags");
		rd(A_DATA, 8'h11, "head data");
		rd(A_FILL, 8'h02, "fill after pop");
		rd(A_QC, 8'h20, "near empty");
		wr(A_QC, 8'h10);
		rd(A_FILL, 8'h00, "cleared");
		rd(A_QC, 8'h20, "clear reads zero");
		// depth changed only once the queue is empty
		wr(A_QC, 8'h84);
		rd(A_QC, 8'ha4, "small depth");
		repeat (253) wr(A_DATA, 8'h5a);
		rd(A_QC, 8'hc4, "near full, msb ignored");
		rd(A_FILL, 8'hfd, "fill 253");
		// two pushes fill the small queue, the third overflows
		repeat (3) wr(A_DATA, 8'h5a);
		rd(A_FILL, 8'hff, "fill stops at 255");
		rd(A_EVS, 8'h07, "overflow event");
		wr(A_QC, 8'h90);
		wr(A_QC, 8'h04);
		repeat (256) wr(A_DATA, 8'ha5);
		rd(A_QC, 8'h65, "large depth, msb, upper bits");
		rd(A_FILL, 8'h00, "fill low byte");
	endtask

	// interrupt masking, clearing and unmapped access
	task automatic t_irq();
		logic [31:0] q;
		logic        e;
		wr(A_QC, 8'h10);
		wr(A_EVS, 8'h0f);
		rd(A_EVS, 8'h00, "status cleared");
		rd(A_DATA, 8'ha5, "underflow read");
		rd(A_EVS, 8'h08, "underflow event");
		chk(irq, 1'b0, "masked irq");
		wr(A_EVM, 8'h08);
		#1 chk(irq, 1'b1, "irq raised");
		wr(A_EVS, 8'h08);
		#1 chk(irq, 1'b0, "irq cleared");
		host.xfer(1'b0, 8'h30, 32'h0, 4'hf, q, e);
		chk({31'h0, e}, 32'h1, "unmapped error");
		chk(q, 32'h0, "unmapped read data");
	endtask

	// hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			$display("Error at %0t: timeout", $time);
			end_of_test();
		end
	end

	initial begin
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_opctl();
		t_bus();
		t_queue();
		t_irq();
		end_of_test();
	end
endmodule // cmd_host_fifo_config_regs_bench

`default_nettype wire
